/* logic/smc_map.svh */
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH
// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define SMC_GROUP_CFG_OFS   16'h200c
`define SMC_DRV_IND_OFS     16'h2150
`define SMC_NEG_IND_OFS     16'h2154
`define SMC_POS_IND_OFS     16'h2158
`define SMC_TIA_IND_OFS     16'h215c
`define SMC_DRV_STA_OFS     16'h21b0
`define SMC_POS_STA_OFS     16'h21b4
`define SMC_NEG_STA_OFS     16'h21b8
`define SMC_TIA_STA_OFS     16'h21bc
// -----------------------------------------------------------------
// reset values and writable masks
// -----------------------------------------------------------------
`define SMC_CFG_RST         32'h0000ffff
`define SMC_IND_RST         16'h0000
`define SMC_CFG_MASK        32'h0007ffff
// -----------------------------------------------------------------
// group configuration fields
// -----------------------------------------------------------------
`define SMC_TIA_EXTRA_B_BIT 18
`define SMC_TIA_EXTRA_A_BIT 17
`define SMC_SEL_BIT         16
`define SMC_TIA_CODE_LSB    12
`define SMC_NEG_CODE_LSB    8
`define SMC_POS_CODE_LSB    4
`define SMC_DRV_CODE_LSB    0
// -----------------------------------------------------------------
// switch bit positions inside the per-group vectors
// -----------------------------------------------------------------
`define SMC_DRV_MASK        16'h00ff
`define SMC_NEG_MASK        16'h0fff
`define SMC_POS_MASK        16'h1fff
`define SMC_TIA_MASK        16'h0bff
`define SMC_TIA_GROUP_MASK  16'h087f
`define SMC_TIA_CAL         16'h0800
`define SMC_TIA_EXTRA_A     16'h0100
`define SMC_TIA_EXTRA_B     16'h0200
`define SMC_NEG_SHORT       16'h0400
`define SMC_NEG_CAL         16'h0200
`define SMC_NEG_SW9         16'h0100
`define SMC_NEG_LDO2        16'h0800
`define SMC_POS_LDO         16'h0800
`define SMC_POS_LDO2        16'h1000
`define SMC_POS_SW11        16'h0400
`define SMC_ONE             16'h0001
`endif

/* logic/smc_pkg.sv */
package smc_pkg;
    // one effective control vector per switch group, 1 = closed
    typedef struct packed {
        logic [15:0] tia;
        logic [15:0] pos;
        logic [15:0] neg;
        logic [15:0] drv;
    } smc_sw_t;

    typedef enum logic [1:0] {
        SMC_RESP_OKAY   = 2'b00,
        SMC_RESP_SLVERR = 2'b10
    } smc_resp_t;
endpackage

/* logic/smc_switch_matrix.sv */
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "smc_map.svh"
// How it works
// [RL1] select bit picks per-switch registers over codes
// [RL2] per-switch writes wait until select is set
// [RL3] tia code: open, single path, calibration
// [RL4] tia 1001 all closed, above opens; extras excluded
// [RL5] tia extras follow config bits 18, 17
// [RL6] neg code: short, singles, nine, calibration
// [RL7] neg 1011-1110 second tie only, 1111 open
// [RL8] pos code: tie, calibration, singles, eleven; code has no pos calibration, 1010 closes nothing
// [RL9] pos 1101-1110 second tie only, 1111 open
// [RL10] drive code: open, calibration, single switches; code has no drive calibration, 0001-1000 close singles
// [RL11] drive 1001 all closed, above all open
// [RL12] config resets to all codes open, group mode
// [RL13] four read-only status registers show switch states
// [RL14] software closes tie switches before hibernation
// [RL15] per-switch registers reset to all open
// [RL16] per-switch bit one closes its switch
// [RL17] status shows effective controls after selection
module smc_switch_matrix
    import smc_pkg::*;
#(
    parameter int ADDR_W = 16
)(
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    input  wire logic [ADDR_W-1:0] i_awaddr,
    input  wire logic              i_awvalid,
    output logic                   o_awready,
    input  wire logic [31:0]       i_wdata,
    input  wire logic [3:0]        i_wstrb,
    input  wire logic              i_wvalid,
    output logic                   o_wready,
    output logic [1:0]             o_bresp,
    output logic                   o_bvalid,
    input  wire logic              i_bready,
    input  wire logic [ADDR_W-1:0] i_araddr,
    input  wire logic              i_arvalid,
    output logic                   o_arready,
    output logic [31:0]            o_rdata,
    output logic [1:0]             o_rresp,
    output logic                   o_rvalid,
    input  wire logic              i_rready,
    output smc_sw_t                o_sw
);
    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                r[b*8 +: 8] = new_v[b*8 +: 8];
        end
        return r;
    endfunction

    function automatic logic [15:0] single(input logic [3:0] code);
        return `SMC_ONE << (code - 4'h1);
    endfunction

    function automatic logic [15:0] dec_tia(input logic [3:0] c);
        logic [15:0] r;
        r = 16'h0000;
        if (c >= 4'h1 && c <= 4'h7)
            r = single(c);                           // [RL3]
        else if (c == 4'h8)
            r = `SMC_TIA_CAL;                        // [RL3]
        else if (c == 4'h9)
            r = `SMC_TIA_GROUP_MASK;                 // [RL4]
        return r;
    endfunction

    function automatic logic [15:0] dec_neg(input logic [3:0] c);
        logic [15:0] r;
        r = 16'h0000;
        if (c == 4'h0)
            r = `SMC_NEG_SHORT;                      // [RL6]
        else if (c <= 4'h7)
            r = single(c);                           // [RL6]
        else if (c == 4'h9)
            r = `SMC_NEG_SW9;                        // [RL6]
        else if (c == 4'ha)
            r = `SMC_NEG_CAL;                        // [RL6]
        else if (c >= 4'hb && c <= 4'he)
            r = `SMC_NEG_LDO2;                       // [RL7]
        return r;
    endfunction

    function automatic logic [15:0] dec_pos(input logic [3:0] c);
        logic [15:0] r;
        r = 16'h0000;
        if (c == 4'h0)
            r = `SMC_POS_LDO;                        // [RL8]
        else if (c <= 4'h9)
            r = single(c);                           // [RL8]
        else if (c == 4'hb)
            r = `SMC_POS_SW11;                       // [RL8]
        else if (c == 4'hd || c == 4'he)
            r = `SMC_POS_LDO2;                       // [RL9]
        return r;
    endfunction

    function automatic logic [15:0] dec_drv(input logic [3:0] c);
        logic [15:0] r;
        r = 16'h0000;
        if (c >= 4'h1 && c <= 4'h8)
            r = single(c);                           // [RL10]
        else if (c == 4'h9)
            r = `SMC_DRV_MASK;                       // [RL11]
        return r;
    endfunction

    // -----------------------------------------------------------------
    // register storage
    // -----------------------------------------------------------------
    logic [31:0] cfg_q;
    logic [31:0] cfg_d;
    logic [15:0] ind_q [4];
    logic [15:0] ind_d [4];
    smc_sw_t     sw_d;

    // -----------------------------------------------------------------
    // write channel
    // -----------------------------------------------------------------
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              aw_held_q;
    logic              w_held_q;
    wire  logic        aw_fire  = i_awvalid & o_awready;
    wire  logic        w_fire   = i_wvalid & o_wready;
    wire  logic        write_do = aw_held_q & w_held_q & ~o_bvalid;
    wire  logic        aw_held_d = ~write_do & (aw_held_q | aw_fire);
    wire  logic        w_held_d  = ~write_do & (w_held_q | w_fire);
    wire  logic        bvalid_d  = write_do | (o_bvalid & ~i_bready);

    wire  logic wr_cfg = awaddr_q == ADDR_W'(`SMC_GROUP_CFG_OFS);
    wire  logic wr_drv = awaddr_q == ADDR_W'(`SMC_DRV_IND_OFS);
    wire  logic wr_neg = awaddr_q == ADDR_W'(`SMC_NEG_IND_OFS);
    wire  logic wr_pos = awaddr_q == ADDR_W'(`SMC_POS_IND_OFS);
    wire  logic wr_tia = awaddr_q == ADDR_W'(`SMC_TIA_IND_OFS);
    wire  logic wr_sta = awaddr_q == ADDR_W'(`SMC_DRV_STA_OFS)
                       | awaddr_q == ADDR_W'(`SMC_POS_STA_OFS)
                       | awaddr_q == ADDR_W'(`SMC_NEG_STA_OFS)
                       | awaddr_q == ADDR_W'(`SMC_TIA_STA_OFS);
    wire  logic wr_hit = wr_cfg | wr_drv | wr_neg | wr_pos | wr_tia | wr_sta;
    // status writes are accepted and dropped, like reserved bits
    wire  logic [31:0] wr_cfg_v = merge(cfg_q, wdata_q, wstrb_q) & `SMC_CFG_MASK;

    always_comb
    begin
        cfg_d = cfg_q;
        for (int g = 0; g < 4; g++)
            ind_d[g] = ind_q[g];
        if (write_do)
        begin
            if (wr_cfg)
                cfg_d = wr_cfg_v;
            else if (wr_drv)
                ind_d[0] = 16'(merge({16'h0000, ind_q[0]}, wdata_q, wstrb_q) & `SMC_DRV_MASK);
            else if (wr_neg)
                ind_d[1] = 16'(merge({16'h0000, ind_q[1]}, wdata_q, wstrb_q) & `SMC_NEG_MASK);
            else if (wr_pos)
                ind_d[2] = 16'(merge({16'h0000, ind_q[2]}, wdata_q, wstrb_q) & `SMC_POS_MASK);
            else if (wr_tia)
                ind_d[3] = 16'(merge({16'h0000, ind_q[3]}, wdata_q, wstrb_q) & `SMC_TIA_MASK);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= SMC_RESP_OKAY;
            awaddr_q  <= '0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end
        else
        begin
            aw_held_q <= aw_held_d;
            w_held_q  <= w_held_d;
            o_awready <= ~aw_held_d;
            o_wready  <= ~w_held_d;
            o_bvalid  <= bvalid_d;
            if (aw_fire)
                awaddr_q <= i_awaddr;
            if (w_fire)
            begin
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
            if (write_do)
                o_bresp <= wr_hit ? SMC_RESP_OKAY : SMC_RESP_SLVERR;
        end
    end

    // -----------------------------------------------------------------
    // switch control registers and effective switch state
    // -----------------------------------------------------------------
    wire  logic sel = cfg_q[`SMC_SEL_BIT];
    wire  logic [15:0] grp_tia = dec_tia(cfg_q[`SMC_TIA_CODE_LSB +: 4])
                               | (cfg_q[`SMC_TIA_EXTRA_A_BIT] ? `SMC_TIA_EXTRA_A : 16'h0000)
                               | (cfg_q[`SMC_TIA_EXTRA_B_BIT] ? `SMC_TIA_EXTRA_B : 16'h0000);

    // per-switch contents reach the switches only through sel, so software
    // may stage them in any order before flipping the source
    always_comb
    begin
        if (sel)
        begin
            sw_d.drv = ind_q[0];                     // [RL1] [RL16]
            sw_d.neg = ind_q[1];                     // [RL1] [RL16]
            sw_d.pos = ind_q[2];                     // [RL1] [RL16]
            sw_d.tia = ind_q[3];                     // [RL1] [RL16]
        end
        else
        begin
            sw_d.drv = dec_drv(cfg_q[`SMC_DRV_CODE_LSB +: 4]);   // [RL1] [RL2]
            sw_d.neg = dec_neg(cfg_q[`SMC_NEG_CODE_LSB +: 4]);   // [RL2]
            sw_d.pos = dec_pos(cfg_q[`SMC_POS_CODE_LSB +: 4]);   // [RL2]
            sw_d.tia = grp_tia;                                  // [RL4] [RL5]
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            cfg_q <= `SMC_CFG_RST;                   // [RL12]
            for (int g = 0; g < 4; g++)
                ind_q[g] <= `SMC_IND_RST;            // [RL15]
            o_sw  <= '0;
        end
        else
        begin
            cfg_q <= cfg_d;
            for (int g = 0; g < 4; g++)
                ind_q[g] <= ind_d[g];
            o_sw  <= sw_d;
        end
    end

    // -----------------------------------------------------------------
    // read channel
    // -----------------------------------------------------------------
    logic [31:0] rd_v;
    logic        rd_hit;
    wire  logic  ar_fire  = i_arvalid & o_arready;
    wire  logic  rvalid_d = ar_fire | (o_rvalid & ~i_rready);

    // status reads return the registered switch drive itself
    always_comb
    begin
        rd_hit = 1'b1;
        rd_v   = 32'h0000_0000;
        if (i_araddr == ADDR_W'(`SMC_GROUP_CFG_OFS))
            rd_v = cfg_q;
        else if (i_araddr == ADDR_W'(`SMC_DRV_IND_OFS))
            rd_v = {16'h0000, ind_q[0]};
        else if (i_araddr == ADDR_W'(`SMC_NEG_IND_OFS))
            rd_v = {16'h0000, ind_q[1]};
        else if (i_araddr == ADDR_W'(`SMC_POS_IND_OFS))
            rd_v = {16'h0000, ind_q[2]};
        else if (i_araddr == ADDR_W'(`SMC_TIA_IND_OFS))
            rd_v = {16'h0000, ind_q[3]};
        else if (i_araddr == ADDR_W'(`SMC_DRV_STA_OFS))
            rd_v = {16'h0000, o_sw.drv};             // [RL13] [RL17]
        else if (i_araddr == ADDR_W'(`SMC_POS_STA_OFS))
            rd_v = {16'h0000, o_sw.pos};             // [RL13] [RL17]
        else if (i_araddr == ADDR_W'(`SMC_NEG_STA_OFS))
            rd_v = {16'h0000, o_sw.neg};             // [RL13] [RL17]
        else if (i_araddr == ADDR_W'(`SMC_TIA_STA_OFS))
            rd_v = {16'h0000, o_sw.tia};             // [RL13] [RL17]
        else
            rd_hit = 1'b0;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= SMC_RESP_OKAY;
        end
        else
        begin
            o_arready <= ~rvalid_d;
            o_rvalid  <= rvalid_d;
            if (ar_fire)
            begin
                o_rdata <= rd_v;
                o_rresp <= rd_hit ? SMC_RESP_OKAY : SMC_RESP_SLVERR;
            end
        end
    end

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    property p_sel_individual;
        sel |=> o_sw.drv == $past(ind_q[0]) && o_sw.tia == $past(ind_q[3]);
    endproperty
    a_sel_individual: assert property (p_sel_individual)  // [RL1]
        else $error("individual source not applied");
    property p_ind_held_off;
        !sel && $stable(cfg_q) |=> $stable(o_sw);
    endproperty
    a_ind_held_off: assert property (p_ind_held_off)  // [RL2]
        else $error("switches moved without select");
    property p_tia_cal;
        !sel && cfg_q[15:12] == 4'h8 |=> (o_sw.tia & `SMC_TIA_GROUP_MASK) == `SMC_TIA_CAL;
    endproperty
    a_tia_cal: assert property (p_tia_cal)  // [RL3]
        else $error("tia calibration code wrong");
    property p_tia_extra;
        !sel |=> o_sw.tia[9:8] == $past(cfg_q[18:17]);
    endproperty
    a_tia_extra: assert property (p_tia_extra)  // [RL5]
        else $error("tia extra switches wrong");
    property p_neg_ldo2;
        !sel && cfg_q[11:8] >= 4'hb && cfg_q[11:8] <= 4'he |=> o_sw.neg == `SMC_NEG_LDO2;
    endproperty
    a_neg_ldo2: assert property (p_neg_ldo2)  // [RL7]
        else $error("neg second tie wrong");
    property p_pos_open;
        !sel && cfg_q[7:4] == 4'hf |=> o_sw.pos == 16'h0000;
    endproperty
    a_pos_open: assert property (p_pos_open)  // [RL9]
        else $error("pos not all open");
    property p_drv_all;
        !sel && cfg_q[3:0] == 4'h9 |=> o_sw.drv == `SMC_DRV_MASK;
    endproperty
    a_drv_all: assert property (p_drv_all)  // [RL11]
        else $error("drive not all closed");
    property p_reset_open;
        $fell(i_reset) |-> cfg_q == `SMC_CFG_RST && ind_q[1] == 16'h0000 ##1 o_sw == '0;
    endproperty
    a_reset_open: assert property (@(posedge i_clk) p_reset_open)  // [RL12] [RL15]
        else $error("reset state wrong");

    property p_status_read;
        ar_fire && i_araddr == ADDR_W'(`SMC_NEG_STA_OFS) |=> o_rvalid && o_rdata[15:0] == $past(o_sw.neg);
    endproperty
    a_status_read: assert property (p_status_read)  // [RL13] [RL17]
        else $error("status read mismatch");

    c_write:     cover property (write_do && wr_cfg);
    c_sel_on:    cover property ($rose(sel));
    c_stat_read: cover property (ar_fire && i_araddr == ADDR_W'(`SMC_TIA_STA_OFS));
    c_bad_addr:  cover property (write_do && !wr_hit);
endmodule // smc_switch_matrix

/* tb/tb_switch_matrix_control.sv */
`timescale 1ns/10ps
`include "smc_map.svh"
module tb_switch_matrix_control
    import smc_pkg::*;
;
    typedef struct packed {
        logic [31:0] cfg;
        smc_sw_t     sw;
    } smc_row_t;

    logic        clk;
    logic        reset;
    logic [15:0] awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [15:0] araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    smc_sw_t     sw;
    smc_sw_t     exp_sw;
    int          n_fail;
    int          n_tests;

    // every group code once, extras toggled on a few rows
    localparam smc_row_t ROWS [16] = '{
        {32'h00000000, 64'h0000_0800_0400_0000},
        {32'h00021111, 64'h0101_0001_0001_0001},
        {32'h00042222, 64'h0202_0002_0002_0002},
        {32'h00063333, 64'h0304_0004_0004_0004},
        {32'h00004444, 64'h0008_0008_0008_0008},
        {32'h00005555, 64'h0010_0010_0010_0010},
        {32'h00006666, 64'h0020_0020_0020_0020},
        {32'h00007777, 64'h0040_0040_0040_0040},
        {32'h00008888, 64'h0800_0080_0000_0080},
        {32'h00069999, 64'h0b7f_0100_0100_00ff},
        {32'h0000aaaa, 64'h0000_0000_0200_0000},
        {32'h0002bbbb, 64'h0100_0400_0800_0000},
        {32'h0000cccc, 64'h0000_0000_0800_0000},
        {32'h0000dddd, 64'h0000_1000_0800_0000},
        {32'h0000eeee, 64'h0000_1000_0800_0000},
        {32'h0000ffff, 64'h0000_0000_0000_0000}
    };

    smc_switch_matrix u_dut (
        .i_clk     (clk),
        .i_reset   (reset),
        .i_awaddr  (awaddr),
        .i_awvalid (awvalid),
        .o_awready (awready),
        .i_wdata   (wdata),
        .i_wstrb   (wstrb),
        .i_wvalid  (wvalid),
        .o_wready  (wready),
        .o_bresp   (bresp),
        .o_bvalid  (bvalid),
        .i_bready  (bready),
        .i_araddr  (araddr),
        .i_arvalid (arvalid),
        .o_arready (arready),
        .o_rdata   (rdata),
        .o_rresp   (rresp),
        .o_rvalid  (rvalid),
        .i_rready  (rready),
        .o_sw      (sw)
    );

    always #50 clk = ~clk;

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    task automatic complete_run();
        if (n_fail == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apply_reset();
        reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // address and data go out together and are released independently
    task automatic axi_write(input logic [15:0] a, input logic [31:0] d,
                             input logic [3:0] s, input logic [1:0] er);
        bit aw_done;
        bit w_done;
        aw_done = 0;
        w_done  = 0;
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge clk);
            if (!aw_done && awready)
            begin
                aw_done = 1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready)
            begin
                w_done = 1;
                wvalid <= 1'b0;
            end
        end
        // bready and rready stay high between calls, so back-to-back calls
        // never drive them twice in one time step
        do @(posedge clk); while (!bvalid);
        cmp({62'h0, bresp}, {62'h0, er});
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        cmp({32'h0, rdata}, {32'h0, e});
        cmp({62'h0, rresp}, {62'h0, er});
    endtask

    // status reads must agree with the switch outputs
    task automatic status_chk(input smc_sw_t e);
        cmp(sw, e);
        rd_chk(`SMC_DRV_STA_OFS, {16'h0, e.drv}, SMC_RESP_OKAY);
        rd_chk(`SMC_POS_STA_OFS, {16'h0, e.pos}, SMC_RESP_OKAY);
        rd_chk(`SMC_NEG_STA_OFS, {16'h0, e.neg}, SMC_RESP_OKAY);
        rd_chk(`SMC_TIA_STA_OFS, {16'h0, e.tia}, SMC_RESP_OKAY);
    endtask

    // -----------------------------------------------------------------
    // watchdog, sized well above the expected run of about 350 cycles
    // -----------------------------------------------------------------
    initial
    begin
        #500000;
        n_fail++;
        complete_run();
    end

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        reset = 1'b1;
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
        n_fail = 0;
        n_tests = 0;
        apply_reset();
        rd_chk(`SMC_GROUP_CFG_OFS, 32'h0000ffff, SMC_RESP_OKAY);
        rd_chk(`SMC_DRV_IND_OFS, 32'h0, SMC_RESP_OKAY);
        rd_chk(`SMC_NEG_IND_OFS, 32'h0, SMC_RESP_OKAY);
        rd_chk(`SMC_POS_IND_OFS, 32'h0, SMC_RESP_OKAY);
        rd_chk(`SMC_TIA_IND_OFS, 32'h0, SMC_RESP_OKAY);
        status_chk('0);
        for (int i = 0; i < 16; i++)
        begin
            axi_write(`SMC_GROUP_CFG_OFS, ROWS[i].cfg, 4'hf, SMC_RESP_OKAY);
            repeat (2) @(posedge clk);
            rd_chk(`SMC_GROUP_CFG_OFS, ROWS[i].cfg, SMC_RESP_OKAY);
            status_chk(ROWS[i].sw);
        end
        // per-switch values staged while the codes still rule, tie switches closed
        axi_write(`SMC_DRV_IND_OFS, 32'hffffff80, 4'hf, SMC_RESP_OKAY);
        axi_write(`SMC_NEG_IND_OFS, 32'h00000c00, 4'hf, SMC_RESP_OKAY);
        axi_write(`SMC_POS_IND_OFS, 32'h00001800, 4'hf, SMC_RESP_OKAY);
        axi_write(`SMC_TIA_IND_OFS, 32'h00000b00, 4'hf, SMC_RESP_OKAY);
        repeat (2) @(posedge clk);
        cmp(sw, 64'h0);
        rd_chk(`SMC_DRV_IND_OFS, 32'h00000080, SMC_RESP_OKAY);
        axi_write(`SMC_GROUP_CFG_OFS, 32'h0001ffff, 4'hf, SMC_RESP_OKAY);
        repeat (2) @(posedge clk);
        exp_sw = {16'h0b00, 16'h1800, 16'h0c00, 16'h0080};
        status_chk(exp_sw);
        axi_write(`SMC_DRV_IND_OFS, 32'h00000001, 4'hf, SMC_RESP_OKAY);
        repeat (2) @(posedge clk);
        exp_sw.drv = 16'h0001;
        status_chk(exp_sw);
        axi_write(`SMC_GROUP_CFG_OFS, 32'h0000ffff, 4'hf, SMC_RESP_OKAY);
        repeat (2) @(posedge clk);
        status_chk('0);
        // status registers ignore writes, unmapped places answer with an error
        axi_write(`SMC_DRV_STA_OFS, 32'h000000ff, 4'hf, SMC_RESP_OKAY);
        rd_chk(`SMC_DRV_STA_OFS, 32'h0, SMC_RESP_OKAY);
        axi_write(16'h2160, 32'h12345678, 4'hf, SMC_RESP_SLVERR);
        rd_chk(16'h2160, 32'h0, SMC_RESP_SLVERR);
        // low byte only: drive and pos codes become 0000
        axi_write(`SMC_GROUP_CFG_OFS, 32'h0, 4'h1, SMC_RESP_OKAY);
        repeat (2) @(posedge clk);
        rd_chk(`SMC_GROUP_CFG_OFS, 32'h0000ff00, SMC_RESP_OKAY);
        cmp(sw, 64'h0000_0800_0000_0000);
        // second reset in mid-run
        axi_write(`SMC_NEG_IND_OFS, 32'h00000001, 4'hf, SMC_RESP_OKAY);
        apply_reset();
        cmp(sw, 64'h0);
        rd_chk(`SMC_GROUP_CFG_OFS, 32'h0000ffff, SMC_RESP_OKAY);
        rd_chk(`SMC_NEG_IND_OFS, 32'h0, SMC_RESP_OKAY);
        complete_run();
    end
endmodule // tb_switch_matrix_control
